// ### shared/csc_pkg.sv
`default_nettype none
package csc_pkg;
    // clock and interface timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_TAG_SETUP_NS = 250;
    // least time, rounded up to whole cycles
    localparam int TAG_SETUP_CYC = (T_TAG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_CYC_DEF = 16;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] TAG_SETUP_CNT = CNT_W'(TAG_SETUP_CYC);

    // status byte positions, byte bit 0 sits in vector bit 7
    localparam int ST_ATTN = 7;
    localparam int ST_SMOD = 6;
    localparam int ST_CUE = 5;
    localparam int ST_BUSY = 4;
    localparam int ST_CE = 3;
    localparam int ST_DE = 2;
    localparam int ST_UC = 1;
    localparam int ST_UE = 0;
    localparam logic [7:0] RETRY_MASK = 8'h4a;

    // unit address layout
    localparam int CU_MSB = 7;
    localparam int DRV_W = 3;

    // synchronised tag vector positions
    localparam int TG_ADR = 0;
    localparam int TG_SEL = 1;
    localparam int TG_HLD = 2;
    localparam int TG_CMD = 3;
    localparam int TG_SVC = 4;
    localparam int TG_SUP = 5;
    localparam int TG_OPR = 6;
    localparam int TG_N = 7;

    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        CSC_IDLE,
        CSC_ADDR,
        CSC_STAT,
        CSC_DATA,
        CSC_ENDW,
        CSC_IFDW
    } csc_state_t;
endpackage
`default_nettype wire

// ### rtl/csc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for channel pins
module csc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule // csc_sync
`default_nettype wire

// ### rtl/csc_seq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csc_seq_ctrl #(
    parameter int RESP_N = 8,
    parameter int SR_CYC = csc_pkg::SR_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic address_out_i,
    input wire logic select_out_i,
    input wire logic hold_out_i,
    input wire logic command_out_i,
    input wire logic service_out_i,
    input wire logic suppress_out_i,
    input wire logic operational_out_i,
    input wire logic [7:0] bus_out_i,
    output logic operational_in_o,
    output logic address_in_o,
    output logic status_in_o,
    output logic service_in_o,
    output logic request_in_o,
    output logic disconnect_in_o,
    output logic mark_in0_o,
    output logic [7:0] bus_in_o,
    input wire logic [3:0] cu_addr_i,
    input wire logic cfg_32sp_i,
    input wire logic [RESP_N-1:0] resp_i,
    input wire logic stat_load_i,
    input wire logic [7:0] stat_i,
    input wire logic stat_retry_i,
    output logic stat_ack_o,
    input wire logic [7:0] init_stat_i,
    output logic [7:0] cmd_o,
    output logic cmd_valid_o,
    input wire logic xfer_req_i,
    input wire logic [7:0] xfer_byte_i,
    output logic xfer_ack_o,
    output logic [7:0] xfer_byte_o,
    input wire logic op_long_i,
    input wire logic fault_i,
    input wire logic sw_pending_i,
    input wire logic sw_ready_i,
    output logic ready_o,
    output logic [1:0] ctl_sel_o,
    output logic [2:0] drive_sel_o,
    output logic chain_o,
    output logic stop_o,
    output logic busy_o,
    output logic sel_reset_o,
    output logic reissue_o
);
    localparam logic [csc_pkg::CNT_W-1:0] SR_CNT = SR_CYC[csc_pkg::CNT_W-1:0];

    logic [csc_pkg::TG_N-1:0] tag_s;
    logic [7:0] bus_s;
    logic adr_s, sel_s, hld_s, cmd_s, svc_s, sup_s, opr_s, opr_d_reg;
    csc_pkg::csc_state_t state_reg;
    logic [csc_pkg::CNT_W-1:0] sup_cnt_reg, ifd_cnt_reg, sr_cnt_reg;
    logic [7:0] pend_byte_reg, cur_addr_reg;
    logic pend_reg, pend_retry_reg, stacked_reg, init_reg, multi_reg;
    logic ifd_seen_reg, ce_done_reg, retry_reg;
    logic sup_q, ifd_det, sr_evt, supp, addr_hit, multi_hit, acc, stk;
    logic [7:0] cur_stat;

    csc_sync #(.W(csc_pkg::TG_N + 8)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({bus_out_i, operational_out_i, suppress_out_i, service_out_i,
              command_out_i, hold_out_i, select_out_i, address_out_i}),
        .q_o({bus_s, tag_s})
    );

    assign adr_s = tag_s[csc_pkg::TG_ADR];
    assign sel_s = tag_s[csc_pkg::TG_SEL];
    assign hld_s = tag_s[csc_pkg::TG_HLD];
    assign cmd_s = tag_s[csc_pkg::TG_CMD];
    assign svc_s = tag_s[csc_pkg::TG_SVC];
    assign sup_s = tag_s[csc_pkg::TG_SUP];
    assign opr_s = tag_s[csc_pkg::TG_OPR];

    // suppress blocks request in only once up long enough
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sup_cnt_reg <= '0;
            ifd_cnt_reg <= '0;
            opr_d_reg <= 1'b0;
        end else begin
            opr_d_reg <= opr_s;
            if (!sup_s)
                sup_cnt_reg <= '0;
            else if (sup_cnt_reg != csc_pkg::TAG_SETUP_CNT)
                sup_cnt_reg <= sup_cnt_reg + 1'b1;
            // address alone must persist to count
            if (!(adr_s && !sel_s && !hld_s))
                ifd_cnt_reg <= '0;
            else if (ifd_cnt_reg != csc_pkg::TAG_SETUP_CNT)
                ifd_cnt_reg <= ifd_cnt_reg + 1'b1;
        end
    end

    assign sup_q = (sup_cnt_reg == csc_pkg::TAG_SETUP_CNT);
    assign ifd_det = (ifd_cnt_reg == csc_pkg::TAG_SETUP_CNT - 1'b1) && adr_s && !sel_s && !hld_s;
    assign sr_evt = opr_d_reg && !opr_s && sup_s;

    always_comb begin
        if (cfg_32sp_i) begin
            addr_hit = (bus_s[csc_pkg::CU_MSB -: 3] == cu_addr_i[3:1]);
            ctl_sel_o = cur_addr_reg[4:3];
        end else begin
            addr_hit = (bus_s[csc_pkg::CU_MSB -: 4] == cu_addr_i);
            ctl_sel_o = {1'b0, cur_addr_reg[3]};
        end
    end
    assign drive_sel_o = cur_addr_reg[csc_pkg::DRV_W-1:0];
    // more than one responder bit set
    assign multi_hit = |(resp_i & (resp_i - 1'b1));

    assign supp = stacked_reg ||
        ((!pend_byte_reg[csc_pkg::ST_CE] || ifd_seen_reg) &&
         (!pend_byte_reg[csc_pkg::ST_DE] || !chain_o));
    assign request_in_o = pend_reg && !(sup_q && supp) && (state_reg == csc_pkg::CSC_IDLE)
        && (sr_cnt_reg == '0);

    assign cur_stat = init_reg
        ? (init_stat_i | (multi_reg ? 8'h02 : csc_pkg::BYTE_RST)) : pend_byte_reg;
    assign acc = (state_reg == csc_pkg::CSC_STAT) && status_in_o && svc_s;
    assign stk = (state_reg == csc_pkg::CSC_STAT) && status_in_o && cmd_s;
    assign busy_o = ce_done_reg || stop_o || (sr_cnt_reg != '0) || pend_reg;

    // tag sequencing toward the channel
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= csc_pkg::CSC_IDLE;
            operational_in_o <= 1'b0;
            address_in_o <= 1'b0;
            status_in_o <= 1'b0;
            service_in_o <= 1'b0;
            mark_in0_o <= 1'b0;
            bus_in_o <= csc_pkg::BYTE_RST;
            init_reg <= 1'b0;
            multi_reg <= 1'b0;
            cur_addr_reg <= csc_pkg::BYTE_RST;
            cmd_o <= csc_pkg::BYTE_RST;
            cmd_valid_o <= 1'b0;
            xfer_ack_o <= 1'b0;
            xfer_byte_o <= csc_pkg::BYTE_RST;
        end else begin
            cmd_valid_o <= 1'b0;
            xfer_ack_o <= 1'b0;
            if (sr_evt) begin
                state_reg <= csc_pkg::CSC_IDLE;
                operational_in_o <= 1'b0;
                address_in_o <= 1'b0;
                status_in_o <= 1'b0;
                service_in_o <= 1'b0;
                mark_in0_o <= 1'b0;
            end else if (ifd_det && state_reg != csc_pkg::CSC_IDLE) begin
                // withdraw all tags but disconnect in
                state_reg <= csc_pkg::CSC_IFDW;
                operational_in_o <= 1'b0;
                address_in_o <= 1'b0;
                status_in_o <= 1'b0;
                service_in_o <= 1'b0;
                mark_in0_o <= 1'b0;
            end else begin
                unique case (state_reg)
                    csc_pkg::CSC_IDLE: begin
                        if (sel_s && adr_s && addr_hit && sr_cnt_reg == '0) begin
                            state_reg <= csc_pkg::CSC_ADDR;
                            operational_in_o <= 1'b1;
                            address_in_o <= 1'b1;
                            bus_in_o <= bus_s;
                            cur_addr_reg <= bus_s;
                            init_reg <= 1'b1;
                            multi_reg <= multi_hit;
                        end else if (sel_s && !adr_s && request_in_o) begin
                            state_reg <= csc_pkg::CSC_ADDR;
                            operational_in_o <= 1'b1;
                            address_in_o <= 1'b1;
                            bus_in_o <= cur_addr_reg;
                            init_reg <= 1'b0;
                        end
                    end
                    csc_pkg::CSC_ADDR: begin
                        if (cmd_s) begin
                            address_in_o <= 1'b0;
                            if (init_reg) begin
                                cmd_o <= bus_s;
                                cmd_valid_o <= 1'b1;
                                state_reg <= csc_pkg::CSC_STAT;
                            end else if (pend_reg) begin
                                state_reg <= csc_pkg::CSC_STAT;
                            end else begin
                                state_reg <= csc_pkg::CSC_DATA;
                            end
                        end
                    end
                    csc_pkg::CSC_STAT: begin
                        // once started, sequence runs to its end unless selective reset or interface disconnect cuts it
                        if (!status_in_o && !cmd_s && !svc_s) begin
                            status_in_o <= 1'b1;
                            bus_in_o <= cur_stat;
                            // mark in zero flags retry status
                            mark_in0_o <= !init_reg && pend_retry_reg;
                        end else if (acc) begin
                            status_in_o <= 1'b0;
                            mark_in0_o <= 1'b0;
                            if (init_reg && !cur_stat[csc_pkg::ST_CE]
                                && !cur_stat[csc_pkg::ST_BUSY] && !multi_reg)
                                state_reg <= csc_pkg::CSC_DATA;
                            else
                                state_reg <= csc_pkg::CSC_ENDW;
                            init_reg <= 1'b0;
                        end else if (stk) begin
                            status_in_o <= 1'b0;
                            mark_in0_o <= 1'b0;
                            init_reg <= 1'b0;
                            state_reg <= csc_pkg::CSC_ENDW;
                        end
                    end
                    csc_pkg::CSC_DATA: begin
                        if (service_in_o && cmd_s) begin
                            service_in_o <= 1'b0;
                            // long ending drops off the interface
                            if (op_long_i) begin
                                operational_in_o <= 1'b0;
                                state_reg <= csc_pkg::CSC_IDLE;
                            end
                        end else if (service_in_o && svc_s) begin
                            service_in_o <= 1'b0;
                            xfer_ack_o <= 1'b1;
                            xfer_byte_o <= bus_s;
                        end else if (!service_in_o && !svc_s && !cmd_s && xfer_req_i
                                     && !stop_o && !pend_reg) begin
                            service_in_o <= 1'b1;
                            bus_in_o <= xfer_byte_i;
                        end else if (!service_in_o && !svc_s && !cmd_s && pend_reg) begin
                            state_reg <= csc_pkg::CSC_STAT;
                        end
                    end
                    csc_pkg::CSC_ENDW: begin
                        if (!sel_s) begin
                            operational_in_o <= 1'b0;
                            state_reg <= csc_pkg::CSC_IDLE;
                        end
                    end
                    csc_pkg::CSC_IFDW: begin
                        if (!adr_s)
                            state_reg <= csc_pkg::CSC_IDLE;
                    end
                endcase
            end
        end
    end

    // pending status, stacking, chaining and retry
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pend_reg <= 1'b0;
            pend_byte_reg <= csc_pkg::BYTE_RST;
            pend_retry_reg <= 1'b0;
            stacked_reg <= 1'b0;
            chain_o <= 1'b0;
            retry_reg <= 1'b0;
            reissue_o <= 1'b0;
            stat_ack_o <= 1'b0;
            ce_done_reg <= 1'b0;
            ifd_seen_reg <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            reissue_o <= 1'b0;
            stat_ack_o <= 1'b0;
            if (sr_evt) begin
                pend_reg <= 1'b0;
                pend_retry_reg <= 1'b0;
                stacked_reg <= 1'b0;
                chain_o <= 1'b0;
                retry_reg <= 1'b0;
                ce_done_reg <= 1'b0;
                ifd_seen_reg <= 1'b0;
                stop_o <= 1'b0;
            end else begin
                if (stat_load_i && !pend_reg) begin
                    pend_reg <= 1'b1;
                    pend_byte_reg <= stat_i;
                    pend_retry_reg <= stat_retry_i;
                    stacked_reg <= 1'b0;
                end
                if (cmd_valid_o)
                    ce_done_reg <= 1'b1;
                if (ifd_det && (ce_done_reg || state_reg != csc_pkg::CSC_IDLE)) begin
                    ifd_seen_reg <= 1'b1;
                    // disconnect before channel end is a stop
                    stop_o <= 1'b1;
                end
                if (state_reg == csc_pkg::CSC_DATA && service_in_o && cmd_s)
                    stop_o <= 1'b1;
                if (acc) begin
                    // unit check or exception blocks it
                    chain_o <= sup_s && !cur_stat[csc_pkg::ST_UC] && !cur_stat[csc_pkg::ST_UE];
                    if (!init_reg) begin
                        pend_reg <= 1'b0;
                        stacked_reg <= 1'b0;
                        stat_ack_o <= 1'b1;
                        retry_reg <= pend_retry_reg && sup_s;
                        if (pend_byte_reg[csc_pkg::ST_DE]) begin
                            // busy lasts until device end is taken
                            ce_done_reg <= 1'b0;
                            ifd_seen_reg <= 1'b0;
                            stop_o <= 1'b0;
                            reissue_o <= retry_reg && sup_s;
                            retry_reg <= 1'b0;
                        end
                    end
                end
                if (stk) begin
                    // status held for a later cycle
                    stacked_reg <= 1'b1;
                    retry_reg <= 1'b0;
                    if (init_reg) begin
                        pend_reg <= 1'b1;
                        pend_byte_reg <= cur_stat;
                        pend_retry_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // reset period counter and switch pickup
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sr_cnt_reg <= '0;
            sel_reset_o <= 1'b0;
            ready_o <= 1'b0;
            disconnect_in_o <= 1'b0;
        end else begin
            sel_reset_o <= sr_evt;
            if (sr_evt) begin
                sr_cnt_reg <= SR_CNT;
                if (sw_pending_i)
                    ready_o <= sw_ready_i;
            end else if (sr_cnt_reg != '0) begin
                sr_cnt_reg <= sr_cnt_reg - 1'b1;
            end
            // fault raises disconnect in, set wins over reset
            if (fault_i)
                disconnect_in_o <= 1'b1;
            else if (sr_evt)
                disconnect_in_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_stat_up;
        status_in_o && state_reg == csc_pkg::CSC_STAT;
    endsequence
    sequence s_stat_acc_chain;
        s_stat_up ##0 svc_s && sup_s && !bus_in_o[csc_pkg::ST_UC] && !bus_in_o[csc_pkg::ST_UE];
    endsequence

    chk_chain_flag_set: assert property (s_stat_acc_chain |=> chain_o)
        else $error("chaining not recognised");
    chk_chain_check_block: assert property (s_stat_up ##0 svc_s && bus_in_o[csc_pkg::ST_UC]
        |=> !chain_o)
        else $error("chaining after unit check");
    chk_stack_hold_drop: assert property (s_stat_up ##0 cmd_s && !svc_s && !ifd_det && !sr_evt
        |=> stacked_reg && pend_reg && !status_in_o)
        else $error("stacked status not held");
    chk_suppress_req_block: assert property (sup_q && stacked_reg |-> !request_in_o)
        else $error("request raised under suppress");
    chk_ifd_tags_drop: assert property (ifd_det && state_reg != csc_pkg::CSC_IDLE && !sr_evt
        |=> !operational_in_o && !status_in_o && !service_in_o && !address_in_o)
        else $error("tags kept after disconnect");
    chk_selreset_busy: assert property (sr_evt |=> !operational_in_o && sel_reset_o
        ##0 busy_o [*8])
        else $error("selective reset not honoured");
    chk_retry_mark_byte: assert property (mark_in0_o |-> status_in_o
        && (bus_in_o & csc_pkg::RETRY_MASK) == csc_pkg::RETRY_MASK && pend_retry_reg)
        else $error("mark in zero without retry status");
    chk_stop_no_service: assert property (stop_o |=> !$rose(service_in_o))
        else $error("service in after stop");
    chk_long_stop_drop: assert property (state_reg == csc_pkg::CSC_DATA && service_in_o
        && cmd_s && op_long_i && !ifd_det && !sr_evt |=> !operational_in_o)
        else $error("operational in kept on long stop");
    chk_disc_in_hold: assert property (disconnect_in_o && !sr_evt |=> disconnect_in_o)
        else $error("disconnect in dropped early");
endmodule // csc_seq_ctrl
`default_nettype wire

// ### bench/csc_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
// channel end of the tag interface, driven through tasks
module csc_chan_model (
    input wire logic clk_i,
    input wire logic operational_in_i,
    input wire logic address_in_i,
    input wire logic status_in_i,
    input wire logic mark_in0_i,
    input wire logic [7:0] bus_in_i,
    output logic address_out_o,
    output logic select_out_o,
    output logic hold_out_o,
    output logic command_out_o,
    output logic service_out_o,
    output logic suppress_out_o,
    output logic operational_out_o,
    output logic [7:0] bus_out_o
);
    // idle interface
    initial begin
        {address_out_o, select_out_o, hold_out_o, command_out_o} = 4'h0;
        {service_out_o, suppress_out_o} = 2'h0;
        operational_out_o = 1'b1;
        bus_out_o = 8'h00;
    end
    // bounded wait for an inbound tag level
    task automatic wt(input int k, input logic v, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 60 && !ok; i++) begin
            @(posedge clk_i);
            ok = ((k == 0) ? operational_in_i : (k == 1) ? address_in_i : status_in_i) === v;
        end
    endtask
    task automatic sup(input logic v);
        @(posedge clk_i);
        suppress_out_o <= v;
    endtask
    task automatic cmd(input logic v);
        @(posedge clk_i);
        command_out_o <= v;
    endtask
    // selection, or reselection when rs is set
    task automatic sel(input logic rs, input logic [7:0] a, output logic ok);
        @(posedge clk_i);
        {select_out_o, hold_out_o, address_out_o} <= {2'h3, !rs};
        bus_out_o <= a;
        wt(1, 1'b1, ok);
        address_out_o <= 1'b0;
        bus_out_o <= ~a;
        if (ok) begin
            command_out_o <= 1'b1;
            wt(1, 1'b0, ok);
            command_out_o <= 1'b0;
        end
        if (!ok) begin
            {select_out_o, hold_out_o} <= 2'h0;
        end
    endtask
    // s: chain flag the channel took from its word; stk: stack
    task automatic acc(input logic s, input logic stk, output logic [7:0] st, output logic mk);
        logic ok;
        // suppress set up before service out, held
        suppress_out_o <= s;
        repeat (26) @(posedge clk_i);
        wt(2, 1'b1, ok);
        st = bus_in_i;
        mk = mark_in0_i;
        command_out_o <= stk;
        service_out_o <= !stk;
        wt(2, 1'b0, ok);
        service_out_o <= 1'b0;
        {select_out_o, hold_out_o} <= 2'h0;
        wt(0, 1'b0, ok);
        // command out held until operational in drops
        command_out_o <= 1'b0;
        suppress_out_o <= 1'b0;
    endtask
    // interface disconnect
    task automatic idisc();
        logic ok;
        {address_out_o, select_out_o, hold_out_o} <= 3'h4;
        wt(0, 1'b0, ok);
        // address low 250 ns before new selection
        address_out_o <= 1'b0;
        repeat (26) @(posedge clk_i);
    endtask
    // selective reset
    task automatic srst();
        suppress_out_o <= 1'b1;
        repeat (26) @(posedge clk_i);
        operational_out_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        {operational_out_o, suppress_out_o, select_out_o, hold_out_o} <= 4'h8;
    endtask
endmodule // csc_chan_model
`default_nettype wire

// ### bench/tb_channel_sequence_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_channel_sequence_control;
    typedef struct packed {
        logic [3:0] cu; logic cfg; logic [7:0] adr; logic [7:0] rsp; logic [7:0] st;
        logic sup; logic ok; logic [1:0] ctl; logic [2:0] drv; logic [7:0] est; logic chn;
    } csc_row_t;
    logic clk_i, nrst_i, adr_o, sel_o, hld_o, cmd_o, svc_o, sup_o, opr_o, ok, mk, cfg_32sp_i;
    logic operational_in_o, address_in_o, status_in_o, service_in_o, request_in_o, mark_in0_o;
    logic stat_load_i, stat_retry_i, sw_pending_i, sw_ready_i, ready_o, chain_o, busy_o;
    logic stat_ack_o, sel_reset_o, reissue_o, stop_o, disconnect_in_o;
    logic op_long_i, fault_i, xfer_req_i;
    logic [7:0] bus_out, bus_in_o, stat_i, init_stat_i, resp_i, st;
    logic [3:0] cu_addr_i;
    logic [1:0] ctl_sel_o;
    logic [2:0] drive_sel_o;
    int n_errors = 0, total_checks = 0, ack_n = 0, rst_n = 0, re_n = 0;
    csc_row_t rows [6] = '{
        '{4'h5, 1'b0, 8'h5b, 8'h01, 8'h0c, 1'b1, 1'b1, 2'h1, 3'h3, 8'h0c, 1'b1},
        '{4'h5, 1'b0, 8'h50, 8'h01, 8'h0e, 1'b1, 1'b1, 2'h0, 3'h0, 8'h0e, 1'b0},
        '{4'h5, 1'b0, 8'h5f, 8'h01, 8'h0c, 1'b0, 1'b1, 2'h1, 3'h7, 8'h0c, 1'b0},
        '{4'ha, 1'b1, 8'hb5, 8'h01, 8'h0d, 1'b1, 1'b1, 2'h2, 3'h5, 8'h0d, 1'b0},
        '{4'h5, 1'b0, 8'h53, 8'h05, 8'h0c, 1'b1, 1'b1, 2'h0, 3'h3, 8'h0e, 1'b0},
        '{4'h5, 1'b0, 8'h63, 8'h01, 8'h0c, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00, 1'b0}};
    csc_chan_model u_chan (.clk_i(clk_i), .operational_in_i(operational_in_o),
        .address_in_i(address_in_o), .status_in_i(status_in_o), .mark_in0_i(mark_in0_o),
        .bus_in_i(bus_in_o), .address_out_o(adr_o), .select_out_o(sel_o), .hold_out_o(hld_o),
        .command_out_o(cmd_o), .service_out_o(svc_o), .suppress_out_o(sup_o),
        .operational_out_o(opr_o), .bus_out_o(bus_out));
    csc_seq_ctrl #(.SR_CYC(8)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .address_out_i(adr_o),
        .select_out_i(sel_o), .hold_out_i(hld_o), .command_out_i(cmd_o), .service_out_i(svc_o),
        .suppress_out_i(sup_o), .operational_out_i(opr_o), .bus_out_i(bus_out),
        .operational_in_o(operational_in_o), .address_in_o(address_in_o),
        .status_in_o(status_in_o), .service_in_o(service_in_o), .request_in_o(request_in_o),
        .disconnect_in_o(disconnect_in_o), .mark_in0_o(mark_in0_o), .bus_in_o(bus_in_o),
        .cu_addr_i(cu_addr_i),
        .cfg_32sp_i(cfg_32sp_i), .resp_i(resp_i), .stat_load_i(stat_load_i), .stat_i(stat_i),
        .stat_retry_i(stat_retry_i), .stat_ack_o(stat_ack_o), .init_stat_i(init_stat_i),
        .cmd_o(), .cmd_valid_o(), .xfer_req_i(xfer_req_i), .xfer_byte_i(8'h00), .xfer_ack_o(),
        .xfer_byte_o(), .op_long_i(op_long_i), .fault_i(fault_i), .sw_pending_i(sw_pending_i),
        .sw_ready_i(sw_ready_i), .ready_o(ready_o), .ctl_sel_o(ctl_sel_o),
        .drive_sel_o(drive_sel_o), .chain_o(chain_o), .stop_o(stop_o), .busy_o(busy_o),
        .sel_reset_o(sel_reset_o), .reissue_o(reissue_o));
    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // pulse counters
    always @(posedge clk_i) begin
        ack_n += (stat_ack_o === 1'b1);
        rst_n += (sel_reset_o === 1'b1);
        re_n += (reissue_o === 1'b1);
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrq();
        for (int i = 0; i < 80 && request_in_o !== 1'b1; i++) @(posedge clk_i);
    endtask
    task automatic load(input logic [7:0] s, input logic r);
        @(posedge clk_i);
        {stat_i, stat_retry_i, stat_load_i} <= {s, r, 1'b1};
        @(posedge clk_i);
        stat_load_i <= 1'b0;
        wrq();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        {nrst_i, cu_addr_i, cfg_32sp_i, resp_i, init_stat_i, fault_i} = '0;
        {stat_load_i, stat_retry_i, stat_i, sw_pending_i, sw_ready_i, op_long_i, xfer_req_i} = '0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk("idle", 8'h00, {operational_in_o, status_in_o, request_in_o, busy_o});
        $display("reset test done");
        foreach (rows[i]) begin
            {cu_addr_i, cfg_32sp_i, resp_i, init_stat_i} <= {rows[i].cu, rows[i].cfg,
                rows[i].rsp, rows[i].st};
            u_chan.sel(1'b0, rows[i].adr, ok);
            chk("accept", rows[i].ok, ok);
            if (ok) begin
                u_chan.acc(rows[i].sup, 1'b0, st, mk);
                chk("ctl", rows[i].ctl, ctl_sel_o);
                chk("drive", rows[i].drv, drive_sel_o);
                chk("status", rows[i].est, st);
                chk("chain", rows[i].chn, chain_o);
            end
            $display("row %0d done", i);
        end
        load(8'h4a, 1'b1);
        u_chan.sel(1'b1, 8'h00, ok);
        u_chan.acc(1'b0, 1'b1, st, mk);
        chk("retry status", {8'h4a}, st);
        chk("mark", 8'h01, mk);
        chk("ack on stack", 8'h00, ack_n);
        u_chan.sup(1'b1);
        repeat (40) @(posedge clk_i);
        chk("suppressed req", 8'h00, request_in_o);
        u_chan.sup(1'b0);
        wrq();
        u_chan.sel(1'b1, 8'h00, ok);
        u_chan.acc(1'b1, 1'b0, st, mk);
        chk("retry taken", 8'h02, {ack_n[0], chain_o});
        load(8'h04, 1'b0);
        u_chan.sel(1'b1, 8'h00, ok);
        u_chan.acc(1'b1, 1'b0, st, mk);
        @(posedge clk_i);
        chk("reissue", 8'h01, re_n);
        $display("retry test done");
        {init_stat_i, resp_i} <= 16'h0801;
        u_chan.sel(1'b0, 8'h54, ok);
        u_chan.idisc();
        chk("disc", 8'h00, {operational_in_o, address_in_o, status_in_o, service_in_o});
        $display("disconnect test done");
        {sw_pending_i, sw_ready_i, fault_i} <= 3'h7;
        u_chan.sel(1'b0, 8'h52, ok);
        fault_i <= 1'b0;
        chk("disc in", 8'h01, disconnect_in_o);
        u_chan.srst();
        chk("sel reset", 8'h05, {operational_in_o, busy_o, rst_n[1:0]});
        repeat (12) @(posedge clk_i);
        chk("ready", 8'h02, {ready_o, disconnect_in_o});
        {init_stat_i, op_long_i, xfer_req_i} <= 10'h003;
        u_chan.sel(1'b0, 8'h51, ok);
        u_chan.acc(1'b0, 1'b0, st, mk);
        u_chan.cmd(1'b1);
        repeat (4) @(posedge clk_i);
        chk("long stop", 8'h01, {operational_in_o, service_in_o, stop_o});
        $display("reset and stop test done");
        wrap_up();
    end
endmodule // tb_channel_sequence_control
`default_nettype wire
